// ===== include/saslm_pkg.sv
// Package: constants and types for the servo alarm and stop manager
package saslm_pkg;
  // Register offsets (plain port, word index)
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_FAULT = 4'h2;
  localparam logic [3:0] ADDR_CFG = 4'h3;
  localparam logic [3:0] ADDR_MON = 4'h4;
  // Fault input bit positions
  localparam int F_PARAM_SUM = 0;
  localparam int F_PARAM_FMT = 1;
  localparam int F_SYS_SUM = 2;
  localparam int F_MAIN_DET = 3;
  localparam int F_PARAM_RANGE = 4;
  localparam int F_ENC_PULSE = 5;
  localparam int F_PARAM_COMB = 6;
  localparam int F_FC_MISMATCH = 7;
  localparam int F_CAPACITY = 8;
  localparam int F_UNSUPPORTED = 9;
  localparam int F_SERVO_ON_CANCEL = 10;
  localparam int F_OVERCURRENT = 11;
  localparam int NUM_FAULTS = 12;
  // Per-alarm properties, bit index = fault position
  localparam logic [11:0] RESETTABLE_MASK = 12'h508;
  localparam logic [11:0] GROUP_TWO_MASK = 12'h000;
  // Alarm code output per fault, bit1 in [0], bit3 in [2]; zero when none given
  localparam logic [2:0] CODE_ENC_PULSE = 3'h7;
  localparam logic [2:0] CODE_OVERCURRENT = 3'h6;
  localparam logic [2:0] CODE_DEFAULT = 3'h0;
  // Alarm numbers shown on the status register
  localparam logic [11:0] ALARM_NUM [NUM_FAULTS] = '{12'h020, 12'h021, 12'h022, 12'h030, 12'h040, 12'h041,
    12'h042, 12'h044, 12'h050, 12'h051, 12'h0B0, 12'h100};
  // Reset values of configuration
  localparam logic [1:0] GR1_STOP_RESET = 2'h0;
  localparam logic [1:0] GR2_STOP_RESET = 2'h0;
  localparam logic [7:0] MON1_RESET = 8'h02;
  localparam logic [7:0] MON2_RESET = 8'h00;
  localparam logic [7:0] MON_POS_ERR = 8'h07;
  // Monitor scale: millivolts per reference unit
  localparam int MON_MV_PER_UNIT = 10;
  // Stop methods
  typedef enum logic [1:0] {SASLM_RUN, SASLM_STOP_DB, SASLM_STOP_ZERO_SPEED, SASLM_STOP_COAST} saslm_stop_t;
endpackage

// ===== design/saslm_monitor.sv
// Monitor channel: selects the motor-to-load position error when coded
`timescale 1ns/1ps
module saslm_monitor #(
  parameter int WIDTH = 16
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [7:0] sel,
  input wire logic signed [WIDTH-1:0] pos_err,
  input wire logic signed [WIDTH-1:0] other_sig,
  output logic signed [WIDTH+3:0] mon_mv
);
  wire logic pick_err = (sel == saslm_pkg::MON_POS_ERR);
  wire logic signed [WIDTH+3:0] scaled_err = (WIDTH + 4)'(pos_err * saslm_pkg::MON_MV_PER_UNIT);
  wire logic signed [WIDTH+3:0] passed = (WIDTH + 4)'(other_sig);
  always_ff @(posedge MCLK)
  begin
    if (RST)
      mon_mv <= '0;
    else
      mon_mv <= pick_err ? scaled_err : passed;
  end
endmodule // saslm_monitor

// ===== design/saslm_top.sv
// Top: alarm latching, stop group selection, code output, monitors, feedback select
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - Group one alarms stop by gr1 select
// - gr1 select defaults to dynamic brake
// - Group two alarms stop by gr2 select
// - gr2 select defaults to zero speed
// - Torque control always uses group one stop
// - gr2 select one copies group one method
// - Resettable alarms clear on a reset request once fault gone
// - Non-resettable alarms ignore reset requests
// - Parameter/system checksum faults: non-resettable alarms
// - Main detector fault: resettable group one alarm
// - Parameter range faults: non-resettable group one
// - Capacity mismatch: resettable group one alarm
// - Unsupported device: non-resettable group one alarm
// - Servo-on after utility power-on raises alarm
// - Overcurrent: non-resettable, code low high high
// - Monitor code 07 shows position error
// - Feedback source 0 motor, 1 external
// - Feedback select ignored unless fully closed
module saslm_top #(
  parameter int WIDTH = 16
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic [11:0] FAULT,
  input wire logic SERVO_ON_REQUEST,
  input wire logic ALARM_RESET_REQUEST,
  input wire logic UTILITY_POWERED,
  input wire logic TORQUE_MODE,
  input wire logic signed [WIDTH-1:0] POS_ERR,
  input wire logic signed [WIDTH-1:0] MON1_SRC,
  input wire logic signed [WIDTH-1:0] MON2_SRC,
  input wire logic signed [WIDTH-1:0] MOTOR_SPEED,
  input wire logic signed [WIDTH-1:0] EXT_SPEED,
  input wire logic RESTART,
  output logic ALARM_CODE_BIT1,
  output logic ALARM_CODE_BIT2,
  output logic ALARM_CODE_BIT3,
  output logic ALARM_ACTIVE,
  output logic [1:0] STOP_ACTION,
  output logic signed [WIDTH+3:0] MON1_OUT,
  output logic signed [WIDTH+3:0] MON2_OUT,
  output logic signed [WIDTH-1:0] SPEED_FB
);
  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: fault lines and host pins come from outside MCLK
  logic [15:0] sync1;
  logic [15:0] sync2;
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= {TORQUE_MODE, UTILITY_POWERED, ALARM_RESET_REQUEST, SERVO_ON_REQUEST, FAULT};
      sync2 <= sync1;
    end
  end
  wire logic [11:0] fault_s = sync2[11:0];
  wire logic son_s = sync2[12];
  wire logic arst_s = sync2[13];
  wire logic util_s = sync2[14];
  wire logic torque_s = sync2[15];

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [1:0] gr1_stop_select;
  logic [1:0] gr2_stop_select;
  logic fully_closed_mode_select;
  logic speed_feedback_select;
  logic speed_feedback_active;
  logic [7:0] monitor1_select;
  logic [7:0] monitor2_select;
  logic son_prev;
  logic arst_prev;
  logic util_seen;
  wire logic wr_cfg = WR && (ADDR == saslm_pkg::ADDR_CFG);
  wire logic wr_mon = WR && (ADDR == saslm_pkg::ADDR_MON);
  wire logic wr_ctrl = WR && (ADDR == saslm_pkg::ADDR_CTRL);
  // Software reset request joins the pin edge; the write strobe is used as is, not edge-detected
  wire logic reset_pulse = (arst_s && !arst_prev) || (wr_ctrl && WDATA[0]);
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      gr1_stop_select <= saslm_pkg::GR1_STOP_RESET;
      gr2_stop_select <= saslm_pkg::GR2_STOP_RESET;
      fully_closed_mode_select <= 1'b0;
      speed_feedback_select <= 1'b0;
      monitor1_select <= saslm_pkg::MON1_RESET;
      monitor2_select <= saslm_pkg::MON2_RESET;
    end
    else
    begin
      if (wr_cfg)
      begin
        gr1_stop_select <= WDATA[1:0];
        gr2_stop_select <= WDATA[5:4];
        fully_closed_mode_select <= WDATA[8];
        speed_feedback_select <= WDATA[12];
      end
      if (wr_mon)
      begin
        monitor1_select <= WDATA[7:0];
        monitor2_select <= WDATA[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Servo-on after a utility run: the host must not, but we catch it
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      son_prev <= 1'b0;
      arst_prev <= 1'b0;
      util_seen <= 1'b0;
    end
    else
    begin
      son_prev <= son_s;
      arst_prev <= arst_s;
      if (util_s)
        util_seen <= 1'b1;
      else if (son_s && !son_prev)
        util_seen <= 1'b0;
    end
  end
  wire logic son_cancel = son_s && !son_prev && util_seen;

  ////////////////////////////////////////////////////////////////////////////
  // Alarm detection and latching
  wire logic [11:0] detect = {fault_s[11], son_cancel, fault_s[9:0]};
  logic [11:0] latched;
  logic [11:0] next_latched;
  genvar g;
  generate
    for (g = 0; g < saslm_pkg::NUM_FAULTS; g++)
    begin : g_alarm
      // Set wins over clear; only resettable alarms with the cause removed may clear
      wire logic may_clear = saslm_pkg::RESETTABLE_MASK[g] && !detect[g];
      assign next_latched[g] = detect[g] || (latched[g] && !(reset_pulse && may_clear));
    end
  endgenerate
  always_ff @(posedge MCLK)
  begin
    if (RST)
      latched <= '0;
    else
      latched <= next_latched;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Priority: lowest alarm number is reported
  logic [3:0] first_idx;
  always_comb
  begin
    first_idx = 4'h0;
    for (int i = saslm_pkg::NUM_FAULTS - 1; i >= 0; i--)
    begin
      if (next_latched[i])
        first_idx = 4'(i);
    end
  end
  wire logic any_alarm = |next_latched;
  wire logic any_g1 = |(next_latched & ~saslm_pkg::GROUP_TWO_MASK);
  wire logic [2:0] code_sel =
    (first_idx == 4'(saslm_pkg::F_ENC_PULSE)) ? saslm_pkg::CODE_ENC_PULSE :
    (first_idx == 4'(saslm_pkg::F_OVERCURRENT)) ? saslm_pkg::CODE_OVERCURRENT :
    saslm_pkg::CODE_DEFAULT;
  wire logic [2:0] next_code = any_alarm ? code_sel : 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Stop method selection
  function automatic logic [1:0] gr1_method(input logic [1:0] sel);
    gr1_method = (sel == 2'h0) ? 2'(saslm_pkg::SASLM_STOP_DB) : 2'(saslm_pkg::SASLM_STOP_COAST);
  endfunction
  wire logic [1:0] g1_action = gr1_method(gr1_stop_select);
  // Group two: torque mode or select 1 falls back to group one method
  wire logic [1:0] g2_action = (torque_s || gr2_stop_select == 2'h1) ? g1_action :
    2'(saslm_pkg::SASLM_STOP_ZERO_SPEED);
  wire logic [1:0] next_stop = !any_alarm ? 2'(saslm_pkg::SASLM_RUN) :
    any_g1 ? g1_action : g2_action;
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      ALARM_CODE_BIT1 <= 1'b0;
      ALARM_CODE_BIT2 <= 1'b0;
      ALARM_CODE_BIT3 <= 1'b0;
      ALARM_ACTIVE <= 1'b0;
      STOP_ACTION <= 2'(saslm_pkg::SASLM_RUN);
    end
    else
    begin
      ALARM_CODE_BIT1 <= next_code[0];
      ALARM_CODE_BIT2 <= next_code[1];
      ALARM_CODE_BIT3 <= next_code[2];
      ALARM_ACTIVE <= any_alarm;
      STOP_ACTION <= next_stop;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Speed feedback source: latched only at restart
  always_ff @(posedge MCLK)
  begin
    if (RST)
      speed_feedback_active <= 1'b0;
    else if (RESTART)
      speed_feedback_active <= speed_feedback_select && fully_closed_mode_select;
  end
  always_ff @(posedge MCLK)
  begin
    if (RST)
      SPEED_FB <= '0;
    else
      SPEED_FB <= speed_feedback_active ? EXT_SPEED : MOTOR_SPEED;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog monitors
  saslm_monitor #(.WIDTH(WIDTH)) u_mon1 (
    .MCLK(MCLK),
    .RST(RST),
    .sel(monitor1_select),
    .pos_err(POS_ERR),
    .other_sig(MON1_SRC),
    .mon_mv(MON1_OUT)
  );
  saslm_monitor #(.WIDTH(WIDTH)) u_mon2 (
    .MCLK(MCLK),
    .RST(RST),
    .sel(monitor2_select),
    .pos_err(POS_ERR),
    .other_sig(MON2_SRC),
    .mon_mv(MON2_OUT)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register read
  wire logic [11:0] shown_num = ALARM_ACTIVE ? saslm_pkg::ALARM_NUM[first_idx] : 12'h000;
  logic [31:0] rd_mux;
  always_comb
  begin
    if (ADDR == saslm_pkg::ADDR_STATUS)
      rd_mux = {14'h0000, STOP_ACTION, ALARM_ACTIVE, ALARM_CODE_BIT3, ALARM_CODE_BIT2, ALARM_CODE_BIT1, shown_num};
    else if (ADDR == saslm_pkg::ADDR_FAULT)
      rd_mux = {20'h00000, latched};
    else if (ADDR == saslm_pkg::ADDR_CFG)
      rd_mux = {16'h0000, 2'h0, speed_feedback_active, speed_feedback_select, 3'h0,
        fully_closed_mode_select, 2'h0, gr2_stop_select, 2'h0, gr1_stop_select};
    else if (ADDR == saslm_pkg::ADDR_MON)
      rd_mux = {16'h0000, monitor2_select, monitor1_select};
    else
      rd_mux = 32'h00000000;
  end
  always_ff @(posedge MCLK)
  begin
    if (RST)
      RDATA <= '0;
    else
      RDATA <= RD ? rd_mux : 32'h00000000;
  end
endmodule // saslm_top

// ===== testbench/saslm_top_asserts.sv
// Checker: alarm, stop, monitor and feedback relations at the top ports
`timescale 1ns/1ps
module saslm_top_asserts #(
  parameter int WIDTH = 16
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic [11:0] FAULT,
  input wire logic signed [WIDTH-1:0] POS_ERR,
  input wire logic signed [WIDTH-1:0] MOTOR_SPEED,
  input wire logic RESTART,
  input wire logic ALARM_CODE_BIT1,
  input wire logic ALARM_CODE_BIT2,
  input wire logic ALARM_CODE_BIT3,
  input wire logic ALARM_ACTIVE,
  input wire logic [1:0] STOP_ACTION,
  input wire logic signed [WIDTH+3:0] MON1_OUT,
  input wire logic signed [WIDTH-1:0] SPEED_FB
);
  logic [1:0] gr1;
  logic [7:0] mon1;
  logic fc;
  // Shadow of the selects, updated on the same edge as the block's own copy
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      gr1 <= 2'h0;
      mon1 <= 8'h02;
      fc <= 1'b0;
    end
    else if (WR && ADDR == 4'h3)
    begin
      gr1 <= WDATA[1:0];
      fc <= WDATA[8];
    end
    else if (WR && ADDR == 4'h4)
      mon1 <= WDATA[7:0];
  end
  ////////////////////////////////////////
  default clocking dcb @(posedge MCLK); endclocking
  default disable iff (RST);
  AST_CODE_ALL_HIGH: assert property (ALARM_CODE_BIT1 |-> ALARM_CODE_BIT2 && ALARM_CODE_BIT3)
    else $error("code bit1 high without bits 2 and 3");
  AST_CODE_NEEDS_ALARM: assert property ((ALARM_CODE_BIT2 || ALARM_CODE_BIT3) |-> ALARM_ACTIVE)
    else $error("alarm code shown with no alarm");
  AST_OC_CODE: assert property ($rose(FAULT[11]) && !ALARM_ACTIVE && FAULT[10:0] == 11'h000 |->
    ##3 ALARM_ACTIVE && !ALARM_CODE_BIT1 && ALARM_CODE_BIT2 && ALARM_CODE_BIT3) else $error("overcurrent code");
  AST_NONRESET_HOLD: assert property (ALARM_CODE_BIT2 |=> ALARM_ACTIVE)
    else $error("non-resettable alarm cleared");
  AST_STOP_TIED: assert property (ALARM_ACTIVE == (STOP_ACTION != 2'h0))
    else $error("stop action disagrees with alarm state");
  AST_GR1_METHOD: assert property ($rose(ALARM_ACTIVE) |-> STOP_ACTION == (gr1 == 2'h0 ? 2'h1 : 2'h3))
    else $error("group one stop method wrong");
  AST_MON_POS_ERR: assert property (mon1 == 8'h07 |=> MON1_OUT == $past(POS_ERR) * 10)
    else $error("monitor 1 position error scale");
  AST_FB_MOTOR: assert property (RESTART && !fc |=> ##1 SPEED_FB == $past(MOTOR_SPEED))
    else $error("feedback not motor encoder in semi-closed mode");
endmodule // saslm_top_asserts
bind saslm_top saslm_top_asserts #(.WIDTH(WIDTH)) saslm_top_asserts_i (.*);

// ===== testbench/saslm_host_model.sv
// Host controller model: servo-on, utility power and alarm reset levels
`timescale 1ns/1ps
module saslm_host_model (
  input wire logic MCLK,
  input wire logic do_reset,
  input wire logic do_utility,
  input wire logic do_servo_on,
  output logic SERVO_ON_REQUEST,
  output logic ALARM_RESET_REQUEST,
  output logic UTILITY_POWERED
);
  logic [2:0] hold = 3'h0;
  initial {SERVO_ON_REQUEST, ALARM_RESET_REQUEST, UTILITY_POWERED} = 3'h0;
  // Reset request is held several cycles so the synchronizer cannot miss it
  always @(posedge MCLK)
  begin
    hold <= do_reset ? 3'h4 : hold - {2'h0, hold != 3'h0};
    ALARM_RESET_REQUEST <= do_reset || hold != 3'h0;
    UTILITY_POWERED <= do_utility;
    SERVO_ON_REQUEST <= do_servo_on;
  end
endmodule // saslm_host_model

// ===== testbench/saslm_top_tb.sv
// Testbench for the servo alarm and stop manager
`timescale 1ns/1ps
module saslm_top_tb;
  localparam int WIDTH = 16;
  logic MCLK = 1'b0, RST = 1'b1, WR = 1'b0, RD = 1'b0, RESTART = 1'b0, TORQUE_MODE = 1'b0;
  logic do_reset = 1'b0, do_utility = 1'b0, do_servo_on = 1'b0;
  logic [3:0] ADDR = 4'h0;
  logic [31:0] WDATA = 32'h0, RDATA;
  logic [11:0] FAULT = 12'h000;
  logic signed [WIDTH-1:0] POS_ERR = 16'hFFFB, MON1_SRC = 16'h8001, MON2_SRC = 16'h0011;
  logic signed [WIDTH-1:0] MOTOR_SPEED = 16'h0123, EXT_SPEED = 16'h0456, SPEED_FB;
  logic ALARM_CODE_BIT1, ALARM_CODE_BIT2, ALARM_CODE_BIT3, ALARM_ACTIVE;
  logic SERVO_ON_REQUEST, ALARM_RESET_REQUEST, UTILITY_POWERED;
  logic [1:0] STOP_ACTION;
  logic signed [WIDTH+3:0] MON1_OUT, MON2_OUT;
  int err_total = 0;
  int samples_checked = 0;
  saslm_top #(.WIDTH(WIDTH)) saslm_top_i (.*);
  saslm_host_model saslm_host_model_i (.*);
  always #2.5 MCLK = ~MCLK;
  ////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    @(negedge MCLK);
    check(what, exp, RDATA);
  endtask
  // One-cycle pulse: 0 alarm reset, 1 servo-on, 2 restart
  task automatic pulse(input int which);
    @(posedge MCLK);
    if (which == 0)
      do_reset <= 1'b1;
    else if (which == 1)
      do_servo_on <= 1'b1;
    else
      RESTART <= 1'b1;
    @(posedge MCLK);
    do_reset <= 1'b0;
    do_servo_on <= 1'b0;
    RESTART <= 1'b0;
    repeat (4) @(negedge MCLK);
  endtask
  task automatic wait_active(input logic lvl);
    int n = 0;
    while (ALARM_ACTIVE !== lvl && n < 12)
    begin
      @(negedge MCLK);
      n++;
    end
    if (n == 12)
    begin
      err_total++;
      $display("BAD alarm_active expected %b seen %b", lvl, ALARM_ACTIVE);
      print_verdict();
    end
  endtask
  task automatic do_rst();
    @(posedge MCLK);
    FAULT <= 12'h000;
    RST <= 1'b1;
    repeat (4) @(posedge MCLK);
    RST <= 1'b0;
  endtask
  ////////////////////////////////////////
  task automatic s_defaults();
    rd(4'h3, 32'h0, "cfg");
    rd(4'h4, 32'h2, "mon");
    rd(4'hF, 32'h0, "unmapped");
  endtask
  task automatic s_locked();
    int bits [9] = '{0, 1, 2, 4, 5, 6, 7, 9, 11};
    foreach (bits[i])
    begin
      do_rst();
      FAULT <= 12'h001 << bits[i];
      wait_active(1'b1);
      check("code", bits[i] == 5 ? 3'h7 : bits[i] == 11 ? 3'h6 : 3'h0,
        {ALARM_CODE_BIT3, ALARM_CODE_BIT2, ALARM_CODE_BIT1});
      check("stop", 2'h1, STOP_ACTION);
      rd(4'h2, 32'h1 << bits[i], "fault");
      if (bits[i] == 11)
        rd(4'h1, 32'h0001E100, "status");
      FAULT <= 12'h000;
      pulse(0);
      wr(4'h0, 32'h1);
      repeat (6) @(negedge MCLK);
      check("held", 1'b1, ALARM_ACTIVE);
    end
    do_rst();
  endtask
  task automatic s_clearable();
    TORQUE_MODE <= 1'b1;
    wr(4'h3, 32'h11);
    for (int b = 3; b <= 10; b++)
    begin
      if (b == 10)
      begin
        do_utility <= 1'b1;
        pulse(1);
      end
      else if (b == 3 || b == 8)
        FAULT <= 12'h001 << b;
      else
        continue;
      wait_active(1'b1);
      check("stop coast", 2'h3, STOP_ACTION);
      rd(4'h2, 32'h1 << b, "fault");
      pulse(0);
      // The servo-on cancel cause is a single event, so it is already gone here
      check("still", (b == 10) ? 1'b0 : 1'b1, ALARM_ACTIVE);
      FAULT <= 12'h000;
      do_utility <= 1'b0;
      repeat (4) @(negedge MCLK);
      if (b == 8)
        wr(4'h0, 32'h1);
      else
        pulse(0);
      wait_active(1'b0);
    end
    TORQUE_MODE <= 1'b0;
  endtask
  task automatic s_monitor();
    wr(4'h4, 32'h0707);
    repeat (3) @(negedge MCLK);
    check("mon1 err", 32'h000FFFCE, {12'h000, MON1_OUT});
    check("mon2 err", 32'h000FFFCE, {12'h000, MON2_OUT});
    wr(4'h4, 32'h0300);
    repeat (3) @(negedge MCLK);
    check("mon1 src", 32'h000F8001, {12'h000, MON1_OUT});
    check("mon2 src", 32'h00000011, {12'h000, MON2_OUT});
  endtask
  task automatic s_feedback();
    wr(4'h3, 32'h1100);
    repeat (3) @(negedge MCLK);
    check("fb before", 32'h0123, {16'h0000, SPEED_FB});
    pulse(2);
    check("fb ext", 32'h0456, {16'h0000, SPEED_FB});
    wr(4'h3, 32'h1000);
    pulse(2);
    check("fb semi", 32'h0123, {16'h0000, SPEED_FB});
  endtask
  initial
  begin
    repeat (4) @(posedge MCLK);
    RST <= 1'b0;
    s_defaults();
    s_locked();
    s_clearable();
    s_monitor();
    s_feedback();
    print_verdict();
  end
endmodule // saslm_top_tb
